// [flag_pkg.sv]
`default_nettype none
package flag_pkg;

    // flag positions in the flag byte
    localparam int FLAG_C = 0;
    localparam int FLAG_V = 1;
    localparam int FLAG_Z = 2;
    localparam int FLAG_N = 3;
    localparam int FLAG_X = 4;
    localparam int FLAG_W = 5;
    localparam logic [FLAG_W-1:0] FLAG_RESET = 5'h00;

    localparam int DATA_W  = 32;
    localparam int SHIFT_W = 6;

    typedef enum logic [1:0] {
        SZ_BYTE = 2'h0,
        SZ_WORD = 2'h1,
        SZ_LONG = 2'h2
    } op_size_e;

    typedef enum logic [3:0] {
        OP_NONE      = 4'h0,
        OP_ADD       = 4'h1,
        OP_SUB       = 4'h2,
        OP_CMP       = 4'h3,
        OP_LOGIC     = 4'h4,
        OP_ADD_EXT   = 4'h5,
        OP_SUB_EXT   = 4'h6,
        OP_DEC_ADD   = 4'h7,
        OP_DEC_SUB   = 4'h8,
        OP_DIVIDE    = 4'h9,
        OP_BIT       = 4'hA,
        OP_ARITH_SHL = 4'hB
    } op_class_e;

    typedef enum logic [3:0] {
        COND_TRUE                = 4'h0,
        COND_FALSE               = 4'h1,
        COND_UNSIGNED_ABOVE      = 4'h2,
        COND_UNSIGNED_NOT_ABOVE  = 4'h3,
        COND_CARRY_CLEAR         = 4'h4,
        COND_CARRY_SET           = 4'h5,
        COND_NOT_EQUAL           = 4'h6,
        COND_EQUAL               = 4'h7,
        COND_OVERFLOW_CLEAR      = 4'h8,
        COND_OVERFLOW_SET        = 4'h9,
        COND_PLUS                = 4'hA,
        COND_MINUS               = 4'hB,
        COND_SIGNED_NOT_LESS     = 4'hC,
        COND_SIGNED_LESS         = 4'hD,
        COND_SIGNED_ABOVE        = 4'hE,
        COND_SIGNED_NOT_ABOVE    = 4'hF
    } cond_sel_e;

    typedef struct packed {
        logic x;
        logic n;
        logic z;
        logic v;
        logic c;
    } flag_byte_s;

    // one operation's flag inputs from the datapath
    typedef struct packed {
        op_class_e          op;
        op_size_e           size;
        logic [DATA_W-1:0]  src;
        logic [DATA_W-1:0]  dst;
        logic [DATA_W-1:0]  res;
        logic               dec_carry;
        logic               div_overflow;
        logic               bit_value;
        logic [SHIFT_W-1:0] shift_count;
    } flag_op_s;

endpackage
`default_nettype wire

// [cond_eval.sv]
`default_nettype none
module cond_eval
    import flag_pkg::*;
(
    // flags and selector
    input  wire flag_byte_s flags,
    input  wire cond_sel_e  sel,
    // result
    output logic            cond_true
);

    always_comb begin
        case (sel)
            COND_TRUE:               cond_true = 1'b1;
            COND_FALSE:              cond_true = 1'b0;
            COND_UNSIGNED_ABOVE:     cond_true = !flags.c && !flags.z;
            COND_UNSIGNED_NOT_ABOVE: cond_true = flags.c || flags.z;
            COND_CARRY_CLEAR:        cond_true = !flags.c;
            COND_CARRY_SET:          cond_true = flags.c;
            COND_NOT_EQUAL:          cond_true = !flags.z;
            COND_EQUAL:              cond_true = flags.z;
            COND_OVERFLOW_CLEAR:     cond_true = !flags.v;
            COND_OVERFLOW_SET:       cond_true = flags.v;
            COND_PLUS:               cond_true = !flags.n;
            COND_MINUS:              cond_true = flags.n;
            COND_SIGNED_NOT_LESS:    cond_true = flags.n == flags.v;
            COND_SIGNED_LESS:        cond_true = flags.n != flags.v;
            COND_SIGNED_ABOVE:       cond_true = (flags.n == flags.v) && !flags.z;
            COND_SIGNED_NOT_ABOVE:   cond_true = flags.z || (flags.n != flags.v);
            default:                 cond_true = 1'b0;
        endcase
    end

endmodule // cond_eval
`default_nettype wire

// [shift_overflow.sv]
`default_nettype none
module shift_overflow
    import flag_pkg::*;
(
    // operand and shift
    input  wire logic [DATA_W-1:0]  dst,
    input  wire logic [5:0]         msb,
    input  wire logic [SHIFT_W-1:0] count,
    // results
    output logic                    ovf,
    output logic                    last_out
);

    logic [DATA_W-1:0] hit;

    // bit i takes part when it lies within count places below the top bit
    genvar gi;
    generate
        for (gi = 0; gi < DATA_W; gi++) begin : g_bit
            assign hit[gi] = (6'(gi) <= msb) && (7'(msb) - 7'(gi) <= 7'(count))
                             && (dst[gi] != dst[msb[4:0]]);
        end
    endgenerate

    always_comb begin
        ovf      = (count != '0) && (hit != '0);
        last_out = 1'b0;
        if (count != '0 && 7'(count) <= 7'(msb) + 7'h01) begin
            last_out = dst[5'(7'(msb) + 7'h01 - 7'(count))];
        end
    end

endmodule // shift_overflow
`default_nettype wire

// [condition_flag_unit.sv]
`default_nettype none
module condition_flag_unit
    import flag_pkg::*;
(
    // clock and reset
    input  wire logic       ref_clk,
    input  wire logic       rst,
    // operation completion from the datapath
    input  wire logic       op_done,
    input  wire flag_op_s   op_in,
    // direct flag byte load
    input  wire logic       flag_load,
    input  wire flag_byte_s flag_load_value,
    // condition query
    input  wire cond_sel_e  cond_sel,
    // outputs
    output flag_byte_s      flag_byte,
    output logic            cond_true_q
);

    ////////////////////////////////////////////////////////////////////////
    // operand top bits

    // top bit index and live bits for each operand size
    localparam logic [5:0]        TOP_BYTE  = 6'h07;
    localparam logic [5:0]        TOP_WORD  = 6'h0F;
    localparam logic [5:0]        TOP_LONG  = 6'h1F;
    localparam logic [DATA_W-1:0] MASK_BYTE = 32'h000000FF;
    localparam logic [DATA_W-1:0] MASK_WORD = 32'h0000FFFF;
    localparam logic [DATA_W-1:0] MASK_LONG = 32'hFFFFFFFF;

    function automatic logic [5:0] top_index(input op_size_e sz);
        case (sz)
            SZ_BYTE: top_index = TOP_BYTE;
            SZ_WORD: top_index = TOP_WORD;
            default: top_index = TOP_LONG;
        endcase
    endfunction

    function automatic logic [DATA_W-1:0] size_mask(input op_size_e sz);
        case (sz)
            SZ_BYTE: size_mask = MASK_BYTE;
            SZ_WORD: size_mask = MASK_WORD;
            default: size_mask = MASK_LONG;
        endcase
    endfunction

    logic [5:0] msb;
    logic       sm;
    logic       dm;
    logic       rm;
    logic       res_zero;

    assign msb      = top_index(op_in.size);
    assign sm       = op_in.src[msb[4:0]];
    assign dm       = op_in.dst[msb[4:0]];
    assign rm       = op_in.res[msb[4:0]];
    assign res_zero = (op_in.res & size_mask(op_in.size)) == '0;

    ////////////////////////////////////////////////////////////////////////
    // arithmetic flag terms

    logic add_v;
    logic add_c;
    logic sub_v;
    logic sub_c;
    logic shl_v;
    logic shl_c;

    assign add_v = (sm && dm && !rm) || (!sm && !dm && rm);
    assign add_c = (sm && dm) || (!rm && dm) || (sm && !rm);
    assign sub_v = (!sm && dm && !rm) || (sm && !dm && rm);
    assign sub_c = (sm && !dm) || (rm && !dm) || (sm && rm);

    shift_overflow u_shift_overflow (
        .dst      (op_in.dst),
        .msb      (msb),
        .count    (op_in.shift_count),
        .ovf      (shl_v),
        .last_out (shl_c)
    );

    ////////////////////////////////////////////////////////////////////////
    // next flag value

    flag_byte_s flags_q;
    flag_byte_s flags_d;

    always_comb begin
        flags_d = flags_q;
        case (op_in.op)
            OP_ADD: begin
                flags_d.n = rm;
                flags_d.z = res_zero;
                flags_d.v = add_v;
                flags_d.c = add_c;
                flags_d.x = add_c;
            end
            OP_SUB: begin
                flags_d.n = rm;
                flags_d.z = res_zero;
                flags_d.v = sub_v;
                flags_d.c = sub_c;
                flags_d.x = sub_c;
            end
            OP_CMP: begin
                flags_d.n = rm;
                flags_d.z = res_zero;
                flags_d.v = sub_v;
                flags_d.c = sub_c;
            end
            OP_LOGIC: begin
                flags_d.n = rm;
                flags_d.z = res_zero;
                flags_d.v = 1'b0;
                flags_d.c = 1'b0;
            end
            OP_ADD_EXT: begin
                flags_d.n = rm;
                flags_d.z = flags_q.z && res_zero;
                flags_d.v = add_v;
                flags_d.c = add_c;
                flags_d.x = add_c;
            end
            OP_SUB_EXT: begin
                flags_d.n = rm;
                flags_d.z = flags_q.z && res_zero;
                flags_d.v = sub_v;
                flags_d.c = sub_c;
                flags_d.x = sub_c;
            end
            OP_DEC_ADD, OP_DEC_SUB: begin
                // negative and overflow left as they were
                flags_d.z = flags_q.z && res_zero;
                flags_d.c = op_in.dec_carry;
                flags_d.x = op_in.dec_carry;
            end
            OP_DIVIDE: begin
                flags_d.n = rm;
                flags_d.z = res_zero;
                flags_d.v = op_in.div_overflow;
                flags_d.c = 1'b0;
            end
            OP_BIT: begin
                flags_d.z = !op_in.bit_value;
            end
            OP_ARITH_SHL: begin
                flags_d.n = rm;
                flags_d.z = res_zero;
                flags_d.v = shl_v;
                flags_d.c = shl_c;
                if (op_in.shift_count != '0) begin
                    flags_d.x = shl_c;
                end
            end
            default: begin
                flags_d = flags_q;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // flag storage

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            flags_q <= FLAG_RESET;
        end else if (op_done) begin
            flags_q <= flags_d;
        end else if (flag_load) begin
            flags_q <= flag_load_value;
        end
    end

    assign flag_byte = flags_q;

    ////////////////////////////////////////////////////////////////////////
    // condition evaluation

    logic cond_now;

    cond_eval u_cond_eval (
        .flags     (flags_q),
        .sel       (cond_sel),
        .cond_true (cond_now)
    );

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            cond_true_q <= 1'b0;
        end else begin
            cond_true_q <= cond_now;
        end
    end

endmodule // condition_flag_unit
`default_nettype wire

// [condition_flag_unit_sva.sv]
`default_nettype none
module condition_flag_unit_sva
    import flag_pkg::*;
(
    // clock and reset
    input wire logic       ref_clk,
    input wire logic       rst,
    // stimulus side
    input wire logic       op_done,
    input wire flag_op_s   op_in,
    input wire logic       flag_load,
    input wire flag_byte_s flag_load_value,
    input wire cond_sel_e  cond_sel,
    // results
    input wire flag_byte_s flag_byte,
    input wire logic       cond_true_q
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff rst;
    sequence s_op(op_class_e k);
        op_done && op_in.op == k;
    endsequence
    ////////////////////////////////////////////////////////////
    AST_RST: assert property ($fell(rst) |-> flag_byte == 5'h00 && !cond_true_q)
        else $error("flags not clear after reset");
    AST_HOLD: assert property (!op_done && !flag_load |=> $stable(flag_byte))
        else $error("flags moved without update");
    AST_LOAD: assert property (flag_load && !op_done |=> flag_byte == $past(flag_load_value))
        else $error("flag load lost");
    AST_XC: assert property (op_done && op_in.op inside {OP_ADD, OP_SUB, OP_ADD_EXT, OP_SUB_EXT,
        OP_DEC_ADD, OP_DEC_SUB} |=> flag_byte.x == flag_byte.c)
        else $error("extend differs from carry");
    AST_LOGIC: assert property (s_op(OP_LOGIC) |=> !flag_byte.v && !flag_byte.c
        && $stable(flag_byte.x))
        else $error("logic op flags wrong");
    AST_DIV: assert property (s_op(OP_DIVIDE) |=> flag_byte.v == $past(op_in.div_overflow)
        && !flag_byte.c && $stable(flag_byte.x))
        else $error("divide flags wrong");
    AST_BIT: assert property (s_op(OP_BIT) |=> flag_byte.z == !$past(op_in.bit_value)
        && $stable({flag_byte.x, flag_byte.n, flag_byte.v, flag_byte.c}))
        else $error("bit op flags wrong");
    AST_STICKY: assert property ((s_op(OP_ADD_EXT) ##0 (!flag_byte.z
        || op_in.res[7:0] != 8'h00)) |=> !flag_byte.z)
        else $error("sticky zero set wrongly");
    AST_EQ: assert property (cond_sel == COND_EQUAL |=> cond_true_q == $past(flag_byte.z))
        else $error("equal test wrong");
    AST_LT: assert property (cond_sel == COND_SIGNED_LESS
        |=> cond_true_q == ($past(flag_byte.n) != $past(flag_byte.v)))
        else $error("signed less test wrong");
endmodule // condition_flag_unit_sva
bind condition_flag_unit condition_flag_unit_sva u_sva (.ref_clk(ref_clk), .rst(rst),
    .op_done(op_done), .op_in(op_in), .flag_load(flag_load), .flag_load_value(flag_load_value),
    .cond_sel(cond_sel), .flag_byte(flag_byte), .cond_true_q(cond_true_q));
`default_nettype wire

// [op_source.sv]
`default_nettype none
module op_source
    import flag_pkg::*;
(
    // clock and reset
    input  wire logic     ref_clk,
    input  wire logic     rst,
    // request from the bench
    input  wire logic     req,
    input  wire flag_op_s cmd,
    // towards the flag unit
    output logic          op_done,
    output flag_op_s      op_in
);
    timeunit 1ns;
    timeprecision 1ps;
    // one-cycle completion, operand bus scrambled while idle
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            op_done <= 1'b0;
            op_in   <= '0;
        end else begin
            op_done <= req;
            op_in   <= req ? cmd : ~op_in;
        end
    end
endmodule // op_source
`default_nettype wire

// [condition_flag_unit_tb_top.sv]
`default_nettype none
module condition_flag_unit_tb_top
    import flag_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic       ref_clk         = 1'b0;
    logic       rst             = 1'b1;
    logic       req             = 1'b0;
    flag_op_s   cmd             = '0;
    logic       flag_load       = 1'b0;
    flag_byte_s flag_load_value = '0;
    cond_sel_e  cond_sel        = COND_TRUE;
    logic       op_done;
    flag_op_s   op_in;
    flag_byte_s flag_byte;
    logic       cond_true_q;
    int         n_errors        = 0;
    int         num_checks      = 0;
    initial begin
        forever #25 ref_clk = ~ref_clk;
    end
    op_source u_src (.ref_clk(ref_clk), .rst(rst), .req(req), .cmd(cmd), .op_done(op_done),
        .op_in(op_in));
    condition_flag_unit dut (.ref_clk(ref_clk), .rst(rst), .op_done(op_done), .op_in(op_in),
        .flag_load(flag_load), .flag_load_value(flag_load_value), .cond_sel(cond_sel),
        .flag_byte(flag_byte), .cond_true_q(cond_true_q));
    ////////////////////////////////////////////////////////////
    task automatic close_out();
        if (n_errors == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic chk5(input logic [4:0] got, input logic [4:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk1(input logic got, input logic exp);
        chk5({4'h0, got}, {4'h0, exp});
    endtask
    task automatic load(input logic [4:0] v);
        @(posedge ref_clk);
        flag_load       <= 1'b1;
        flag_load_value <= v;
        @(posedge ref_clk);
        flag_load <= 1'b0;
        #1;
    endtask
    // e is {dec_carry, div_overflow, bit_value}
    task automatic run(input op_class_e op, input op_size_e sz, input logic [31:0] s, d, r,
                       input logic [2:0] e, input logic [5:0] sc, input logic [4:0] exp);
        @(posedge ref_clk);
        req <= 1'b1;
        cmd <= '{op, sz, s, d, r, e[2], e[1], e[0], sc};
        @(posedge ref_clk);
        req <= 1'b0;
        @(posedge ref_clk);
        #1;
        chk5(flag_byte, exp);
    endtask
    function automatic logic cref(input logic [4:0] f, input logic [3:0] s);
        logic x, n, z, v, c, b;
        {x, n, z, v, c} = f;
        case (s[3:1])
            3'h0: b = 1'b1;
            3'h1: b = !c && !z;
            3'h2: b = !c;
            3'h3: b = !z;
            3'h4: b = !v;
            3'h5: b = !n;
            3'h6: b = n == v;
            default: b = !z && n == v;
        endcase
        return b ^ s[0];
    endfunction
    initial begin
        repeat (6) @(posedge ref_clk);
        rst <= 1'b0;
        #1;
        chk5(flag_byte, 5'h00);
        chk1(cond_true_q, 1'b0);
        for (int p = 0; p < 32; p++) begin
            load(p[4:0]);
            for (int s = 0; s < 16; s++) begin
                @(posedge ref_clk);
                cond_sel <= cond_sel_e'(s[3:0]);
                @(posedge ref_clk);
                #1;
                chk1(cond_true_q, cref(p[4:0], s[3:0]));
            end
        end
        run(OP_ADD, SZ_BYTE, 32'h80, 32'h80, 32'h0, 3'h0, 6'h0, 5'h17);
        run(OP_SUB, SZ_WORD, 32'h1, 32'h0, 32'hFFFF, 3'h0, 6'h0, 5'h19);
        run(OP_CMP, SZ_LONG, 32'h1, 32'h80000000, 32'h7FFFFFFF, 3'h0, 6'h0, 5'h12);
        run(OP_DIVIDE, SZ_WORD, 32'h0, 32'h0, 32'h8000, 3'h0, 6'h0, 5'h18);
        run(OP_LOGIC, SZ_BYTE, 32'h0, 32'h0, 32'hFF00, 3'h0, 6'h0, 5'h14);
        run(OP_DIVIDE, SZ_WORD, 32'h0, 32'h0, 32'h1, 3'h2, 6'h0, 5'h12);
        run(OP_BIT, SZ_LONG, 32'h0, 32'h0, 32'h0, 3'h0, 6'h0, 5'h16);
        run(OP_BIT, SZ_BYTE, 32'h0, 32'h0, 32'h0, 3'h1, 6'h0, 5'h12);
        load(5'h04);
        run(OP_ADD_EXT, SZ_BYTE, 32'h0, 32'h0, 32'h0, 3'h0, 6'h0, 5'h04);
        run(OP_ADD_EXT, SZ_BYTE, 32'h1, 32'h0, 32'h1, 3'h0, 6'h0, 5'h00);
        run(OP_ADD_EXT, SZ_BYTE, 32'hFF, 32'h1, 32'h0, 3'h0, 6'h0, 5'h11);
        load(5'h0E);
        run(OP_DEC_ADD, SZ_BYTE, 32'h0, 32'h0, 32'h0, 3'h4, 6'h0, 5'h1F);
        run(OP_DEC_SUB, SZ_BYTE, 32'h0, 32'h0, 32'h1, 3'h0, 6'h0, 5'h0A);
        run(OP_ARITH_SHL, SZ_BYTE, 32'h0, 32'hC0, 32'h0, 3'h0, 6'h2, 5'h17);
        run(OP_ARITH_SHL, SZ_BYTE, 32'h0, 32'h40, 32'h80, 3'h0, 6'h1, 5'h0A);
        run(OP_ARITH_SHL, SZ_BYTE, 32'h0, 32'h81, 32'h81, 3'h0, 6'h0, 5'h08);
        run(OP_NONE, SZ_BYTE, 32'h0, 32'h0, 32'h0, 3'h0, 6'h0, 5'h08);
        run(OP_SUB_EXT, SZ_BYTE, 32'h1, 32'h0, 32'hFF, 3'h0, 6'h0, 5'h19);
        close_out();
    end
    initial begin
        repeat (5000) @(posedge ref_clk);
        n_errors++;
        close_out();
    end
endmodule // condition_flag_unit_tb_top
`default_nettype wire
